// ==== pc_stack_regs.vh ====
// constants for the program counter, return stack and indirect address block
// included by pc_branch_stack_indirect_addr.v only
`ifndef PC_STACK_REGS_VH
`define PC_STACK_REGS_VH
`define OFF_INDIRECT_DATA_PORT_0 4'h0
`define OFF_INDIRECT_DATA_PORT_1 4'h1
`define OFF_ADDR_LOW_0 4'h4
`define OFF_ADDR_HIGH_0 4'h5
`define OFF_ADDR_LOW_1 4'h6
`define OFF_ADDR_HIGH_1 4'h7
`define OFF_PC_HIGH_LATCH 4'ha
`define OFF_STACK_POINTER 4'hb
`define OFF_TOS_LOW 4'hc
`define OFF_TOS_HIGH 4'hd
`define OFF_STACK_STATUS 4'he
`define STACK_DEPTH 16
`define STACK_PTR_EMPTY 5'h1f
`define STACK_PTR_TOP 5'h0f
`define BANKED_LAST 16'h1fff
`define LINEAR_BASE 16'h2000
`define LINEAR_LAST 16'h2fef
`define GPR_BLOCK 7'h50
`define GPR_FIRST 7'h20
`define BANK_SIZE 7'h80
`define LINEAR_BANKS 6'h32
`define RESET_BYTE 8'h00
`endif

// ==== pc_branch_stack_indirect_addr.v ====
// program counter branch targets, return stack and indirect address decode
// assumes one core clock, decoder strobes of one cycle, external data and flash memories
// Functional notes
// - register branch: pc becomes incremented pc plus unsigned working register
// - literal branch: pc becomes incremented pc plus signed operand
// - sixteen entry fifteen bit return stack, separate storage
// - push pc on call, indirect call and interrupt entry
// - pop on return, return with literal, return from interrupt
// - pushes and pops leave the high latch unchanged
// - without fault reset the stack wraps circularly
// - overflow and underflow flags set regardless of fault reset
// - with fault reset enabled, overflow or underflow resets the device
// - pointer increments on push, decrements on pop, marks occupied entry
// - push increments then writes; pop reads then decrements
// - pointer and top of stack pair readable and writable by software
// - indirect data port accesses location given by its address pointer
// - pointer at an indirect data port reads zero, write suppressed
// - sixteen bit pointer formed from high and low bytes
// - 0x0000 to 0x1fff map straight to banked data memory
// - 0x2000 to 0x2fef map contiguously onto 80 byte blocks
// - unimplemented linear locations read as zero
// - common memory is outside the linear region
// - msb set addresses flash, low byte of word returned
// - indirect writes never modify flash
// - indirect flash read takes one extra cycle
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pc_stack_regs.vh"
module pc_branch_stack_indirect_addr
(
   // clock and reset
   input wire clk_in,
   input wire reset_in,
   // configuration
   input wire stack_fault_reset_enable_in,
   input wire [5:0] implemented_banks_in,
   // decoder requests
   input wire branch_by_working_reg_in,
   input wire branch_by_literal_in,
   input wire [8:0] branch_operand_in,
   input wire [7:0] working_reg_in,
   input wire [14:0] pc_in,
   input wire push_in,
   input wire [14:0] push_value_in,
   input wire pop_in,
   // register port
   input wire [3:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   output reg [7:0] reg_rdata_out,
   // data memory
   output reg [12:0] mem_addr_out,
   output reg [7:0] mem_wdata_out,
   output wire mem_write_out,
   output wire mem_read_out,
   input wire [7:0] mem_rdata_in,
   // program flash
   output reg [14:0] flash_addr_out,
   output wire flash_read_out,
   input wire [13:0] flash_rdata_in,
   // results
   output reg pc_load_out,
   output reg [14:0] pc_target_out,
   output reg [14:0] pop_value_out,
   output wire indirect_stall_out,
   output reg stack_reset_out
);
   localparam REG_NONE = 3'b001;
   localparam REG_MEM = 3'b010;
   localparam REG_FLASH = 3'b100;
   reg [14:0] stack_mem [0:`STACK_DEPTH-1];
   reg [4:0] sp_q;
   reg [7:0] ptr_low_q [0:1];
   reg [7:0] ptr_high_q [0:1];
   reg [6:0] high_latch_q;
   reg ovf_q;
   reg unf_q;
   reg [2:0] rd_state_q;
   reg [7:0] zero_q;
   reg [7:0] rdata_d;
   reg [2:0] rd_state_d;
   reg [4:0] sp_d;
   reg do_push;
   reg do_pop;
   reg ovf_ev;
   reg unf_ev;
   wire sel;
   wire [15:0] ind_addr;
   wire ind_access;
   wire is_port;
   wire is_flash;
   wire is_banked;
   wire is_linear;
   wire lin_ok;
   wire [11:0] lin_off;
   wire [5:0] lin_bank;
   wire [6:0] lin_rem;
   integer i;
   // 16 bit pointer of the selected port
   assign sel = reg_addr_in[0];
   assign ind_addr = {ptr_high_q[sel], ptr_low_q[sel]};
   assign ind_access = (reg_addr_in[3:1] == 3'h0) & (reg_read_in | reg_write_in);
   assign is_port = (ind_addr[15:1] == 15'h0000);
   assign is_flash = ind_addr[15];
   assign is_banked = ~is_flash & (ind_addr <= `BANKED_LAST) & ~is_port;
   assign is_linear = (ind_addr >= `LINEAR_BASE) & (ind_addr <= `LINEAR_LAST);
   assign lin_off = ind_addr[11:0];
   assign lin_bank = div80(lin_off);
   assign lin_rem = rem80(lin_off);
   assign lin_ok = is_linear & (lin_bank < implemented_banks_in);
   assign mem_read_out = ind_access & reg_read_in & (is_banked | lin_ok);
   assign mem_write_out = ind_access & reg_write_in & (is_banked | lin_ok);
   assign flash_read_out = ind_access & reg_read_in & is_flash;
   assign indirect_stall_out = flash_read_out;
   function [5:0] div80;
      input [11:0] off;
      begin
         div80 = 6'h00;
         for (i = 1; i < 52; i = i + 1)
            if ({20'h00000, off} >= i * 80)
               div80 = i[5:0];
      end
   endfunction
   function [6:0] rem80;
      input [11:0] off;
      reg [12:0] base;
      begin
         base = {7'h00, div80(off)} * 13'd80;
         rem80 = off[6:0] - base[6:0];
      end
   endfunction
   // memory address: banked direct, linear into gpr block, commons excluded
   always @*
   begin
      mem_wdata_out = reg_wdata_in;
      flash_addr_out = ind_addr[14:0];
      if (is_linear)
         mem_addr_out = {lin_bank, 7'h00} + {6'h00, `GPR_FIRST} + {6'h00, lin_rem};
      else
         mem_addr_out = ind_addr[12:0];
   end
   // branch targets
   always @*
   begin
      pc_load_out = branch_by_working_reg_in | branch_by_literal_in;
      if (branch_by_working_reg_in)
         pc_target_out = pc_in + 15'h0001 + {7'h00, working_reg_in};
      else
         pc_target_out = pc_in + 15'h0001 + {{6{branch_operand_in[8]}}, branch_operand_in};
   end
   // push and pop with pointer
   always @*
   begin
      do_push = push_in & ~pop_in;
      do_pop = pop_in & ~push_in;
      ovf_ev = do_push & (sp_q == `STACK_PTR_TOP);
      unf_ev = do_pop & (sp_q == `STACK_PTR_EMPTY);
      sp_d = sp_q;
      if (do_push)
         sp_d = (sp_q == `STACK_PTR_TOP) ? 5'h00 : sp_q + 5'h01;
      else if (do_pop)
         sp_d = (sp_q == 5'h00) ? `STACK_PTR_EMPTY : sp_q - 5'h01;
      else if (reg_write_in & (reg_addr_in == `OFF_STACK_POINTER))
         sp_d = reg_wdata_in[4:0];
      pop_value_out = stack_mem[sp_q[3:0]];
   end
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         sp_q <= `STACK_PTR_EMPTY;
         ptr_low_q[0] <= `RESET_BYTE;
         ptr_low_q[1] <= `RESET_BYTE;
         ptr_high_q[0] <= `RESET_BYTE;
         ptr_high_q[1] <= `RESET_BYTE;
         high_latch_q <= 7'h00;
         stack_reset_out <= 1'b0;
      end
      else
      begin
         sp_q <= sp_d;
         stack_reset_out <= stack_fault_reset_enable_in & (ovf_ev | unf_ev);
         if (reg_write_in)
            case (reg_addr_in)
               `OFF_ADDR_LOW_0: ptr_low_q[0] <= reg_wdata_in;
               `OFF_ADDR_HIGH_0: ptr_high_q[0] <= reg_wdata_in;
               `OFF_ADDR_LOW_1: ptr_low_q[1] <= reg_wdata_in;
               `OFF_ADDR_HIGH_1: ptr_high_q[1] <= reg_wdata_in;
               `OFF_PC_HIGH_LATCH: high_latch_q <= reg_wdata_in[6:0];
               default: high_latch_q <= high_latch_q;
            endcase
      end
   end
   // stack storage, no reset
   always @(posedge clk_in)
   begin
      if (do_push)
         stack_mem[sp_d[3:0]] <= push_value_in;
      else if (reg_write_in & (reg_addr_in == `OFF_TOS_LOW))
         stack_mem[sp_q[3:0]] <= {stack_mem[sp_q[3:0]][14:8], reg_wdata_in};
      else if (reg_write_in & (reg_addr_in == `OFF_TOS_HIGH))
         stack_mem[sp_q[3:0]] <= {reg_wdata_in[6:0], stack_mem[sp_q[3:0]][7:0]};
   end
   // flags survive the fault reset; set wins over software clear
   always @(posedge clk_in)
   begin
      if (reset_in & ~stack_reset_out)
      begin
         ovf_q <= 1'b0;
         unf_q <= 1'b0;
      end
      else
      begin
         if (ovf_ev)
            ovf_q <= 1'b1;
         else if (reg_write_in & (reg_addr_in == `OFF_STACK_STATUS) & ~reg_wdata_in[0])
            ovf_q <= 1'b0;
         if (unf_ev)
            unf_q <= 1'b1;
         else if (reg_write_in & (reg_addr_in == `OFF_STACK_STATUS) & ~reg_wdata_in[1])
            unf_q <= 1'b0;
      end
   end
   // read path, data one cycle later
   always @*
   begin
      rdata_d = 8'h00;
      rd_state_d = REG_NONE;
      if (reg_read_in)
         case (reg_addr_in)
            `OFF_INDIRECT_DATA_PORT_0, `OFF_INDIRECT_DATA_PORT_1:
            begin
               if (is_flash)
                  rd_state_d = REG_FLASH;
               else if (is_banked | lin_ok)
                  rd_state_d = REG_MEM;
               else
                  rdata_d = 8'h00;
            end
            `OFF_ADDR_LOW_0: rdata_d = ptr_low_q[0];
            `OFF_ADDR_HIGH_0: rdata_d = ptr_high_q[0];
            `OFF_ADDR_LOW_1: rdata_d = ptr_low_q[1];
            `OFF_ADDR_HIGH_1: rdata_d = ptr_high_q[1];
            `OFF_PC_HIGH_LATCH: rdata_d = {1'b0, high_latch_q};
            `OFF_STACK_POINTER: rdata_d = {3'h0, sp_q};
            `OFF_TOS_LOW: rdata_d = stack_mem[sp_q[3:0]][7:0];
            `OFF_TOS_HIGH: rdata_d = {1'b0, stack_mem[sp_q[3:0]][14:8]};
            `OFF_STACK_STATUS: rdata_d = {6'h00, unf_q, ovf_q};
            default: rdata_d = 8'h00;
         endcase
   end
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         rd_state_q <= REG_NONE;
         zero_q <= 8'h00;
      end
      else
      begin
         rd_state_q <= rd_state_d;
         zero_q <= rdata_d;
      end
   end
   always @*
   begin
      case (rd_state_q)
         REG_MEM: reg_rdata_out = mem_rdata_in;
         REG_FLASH: reg_rdata_out = flash_rdata_in[7:0];
         REG_NONE: reg_rdata_out = zero_q;
         default: reg_rdata_out = 8'h00;
      endcase
   end
endmodule // pc_branch_stack_indirect_addr
`default_nettype wire

// ==== mem_partner.sv ====
// data memory and program flash model on the far side of the block
// answers one cycle after a strobe, scrambles its outputs otherwise
`timescale 1ns/100ps
`default_nettype none
module mem_partner
(
   // clock
   input wire logic clk_in,
   // data memory
   input wire logic [12:0] mem_addr_in,
   input wire logic [7:0] mem_wdata_in,
   input wire logic mem_write_in,
   input wire logic mem_read_in,
   output var logic [7:0] mem_rdata_out = 8'h00,
   // program flash, read only
   input wire logic [14:0] flash_addr_in,
   input wire logic flash_read_in,
   output var logic [13:0] flash_rdata_out = 14'h0000
);
   logic [7:0] ram [0:8191];
   always @(posedge clk_in)
   begin
      if (mem_write_in)
         ram[mem_addr_in] <= mem_wdata_in;
      mem_rdata_out <= mem_read_in ? ram[mem_addr_in] : ~mem_rdata_out;
      // flash has no write path
      flash_rdata_out <= flash_read_in ? {~flash_addr_in[13:8], flash_addr_in[7:0] ^ 8'ha5} :
         ~flash_rdata_out;
   end
endmodule // mem_partner
`default_nettype wire

// ==== pc_stack_chk.sv ====
// port level checks of branch, stack fault and indirect access behaviour
// bound to the top module, sees its ports only
`timescale 1ns/100ps
`default_nettype none
module pc_stack_chk
(
   // clock, reset, requests
   input wire clk_in,
   input wire reset_in,
   input wire stack_fault_reset_enable_in,
   input wire branch_by_working_reg_in,
   input wire branch_by_literal_in,
   input wire [8:0] branch_operand_in,
   input wire [7:0] working_reg_in,
   input wire [14:0] pc_in,
   input wire push_in,
   input wire pop_in,
   input wire [3:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   input wire [7:0] mem_rdata_in,
   input wire [13:0] flash_rdata_in,
   // results
   input wire [7:0] reg_rdata_out,
   input wire [7:0] mem_wdata_out,
   input wire mem_write_out,
   input wire mem_read_out,
   input wire flash_read_out,
   input wire pc_load_out,
   input wire [14:0] pc_target_out,
   input wire indirect_stall_out,
   input wire stack_reset_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   property p_brw;
      branch_by_working_reg_in |-> pc_load_out && pc_target_out == pc_in + 15'h1 + working_reg_in;
   endproperty
   a_brw: assert property (p_brw) else $error("bad register branch");
   property p_bra;
      branch_by_literal_in |-> pc_load_out &&
         pc_target_out == pc_in + 15'h1 + {{6{branch_operand_in[8]}}, branch_operand_in};
   endproperty
   a_bra: assert property (p_bra) else $error("bad literal branch");
   property p_stl;
      flash_read_out |-> indirect_stall_out;
   endproperty
   a_stl: assert property (p_stl) else $error("no stall");
   property p_mwr;
      mem_write_out |-> reg_write_in && reg_addr_in[3:1] == 3'h0 && mem_wdata_out == reg_wdata_in;
   endproperty
   a_mwr: assert property (p_mwr) else $error("bad memory write");
   property p_mrd;
      mem_read_out |=> reg_rdata_out == mem_rdata_in;
   endproperty
   a_mrd: assert property (p_mrd) else $error("bad memory read");
   property p_frd;
      flash_read_out |=> reg_rdata_out == flash_rdata_in[7:0];
   endproperty
   a_frd: assert property (p_frd) else $error("bad flash byte");
   property p_fsel;
      flash_read_out |-> reg_read_in && reg_addr_in[3:1] == 3'h0 && !mem_read_out;
   endproperty
   a_fsel: assert property (p_fsel) else $error("bad flash select");
   property p_flt;
      stack_reset_out |-> $past(stack_fault_reset_enable_in && (push_in || pop_in));
   endproperty
   a_flt: assert property (p_flt) else $error("bad stack reset");
   c_brw: cover property (branch_by_working_reg_in);
   c_frd: cover property (flash_read_out);
   c_flt: cover property (stack_reset_out);
endmodule // pc_stack_chk
bind pc_branch_stack_indirect_addr pc_stack_chk chk_inst (.clk_in, .reset_in,
   .stack_fault_reset_enable_in, .branch_by_working_reg_in, .branch_by_literal_in,
   .branch_operand_in, .working_reg_in, .pc_in, .push_in, .pop_in, .reg_addr_in, .reg_wdata_in,
   .reg_write_in, .reg_read_in, .mem_rdata_in, .flash_rdata_in, .reg_rdata_out, .mem_wdata_out,
   .mem_write_out, .mem_read_out, .flash_read_out, .pc_load_out, .pc_target_out,
   .indirect_stall_out, .stack_reset_out);
`default_nettype wire

// ==== tb_pc_branch_stack_indirect_addr.sv ====
// testbench for branch targets, return stack and indirect access
// drives the decoder and register port, memories come from mem_partner
`timescale 1ns/100ps
`default_nettype none
module tb_pc_branch_stack_indirect_addr;
   logic clk = 1'b0, rst = 1'b1, fre = 1'b0, branch_by_working_reg = 1'b0, branch_by_literal = 1'b0;
   logic push = 1'b0, pop = 1'b0, we = 1'b0, re = 1'b0;
   logic [5:0] banks = 6'h02;
   logic [8:0] opnd = 9'h000;
   logic [7:0] wreg = 8'h00, wd = 8'h00;
   logic [14:0] pc = 15'h0000, pushv = 15'h0000;
   logic [3:0] ra = 4'h0;
   wire [7:0] rdata, mwd, mrdata;
   wire [12:0] maddr;
   wire [14:0] faddr, pct, popv;
   wire [13:0] fdata;
   wire mwr, mrd, frd, program_counter_low, stall, sres;
   int n_errors = 0, checked = 0;
   pc_branch_stack_indirect_addr pc_branch_stack_indirect_addr_inst (.clk_in(clk), .reset_in(rst),
      .stack_fault_reset_enable_in(fre), .implemented_banks_in(banks),
      .branch_by_working_reg_in(branch_by_working_reg), .branch_by_literal_in(branch_by_literal), .branch_operand_in(opnd),
      .working_reg_in(wreg), .pc_in(pc), .push_in(push), .push_value_in(pushv), .pop_in(pop),
      .reg_addr_in(ra), .reg_wdata_in(wd), .reg_write_in(we), .reg_read_in(re),
      .reg_rdata_out(rdata), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_write_out(mwr),
      .mem_read_out(mrd), .mem_rdata_in(mrdata), .flash_addr_out(faddr), .flash_read_out(frd),
      .flash_rdata_in(fdata), .pc_load_out(program_counter_low), .pc_target_out(pct), .pop_value_out(popv),
      .indirect_stall_out(stall), .stack_reset_out(sres));
   mem_partner mem_partner_inst (.clk_in(clk), .mem_addr_in(maddr), .mem_wdata_in(mwd),
      .mem_write_in(mwr), .mem_read_in(mrd), .mem_rdata_out(mrdata), .flash_addr_in(faddr),
      .flash_read_in(frd), .flash_rdata_out(fdata));
   initial
      forever #10 clk = ~clk;
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      ra <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task setp(input logic [3:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 4'h1, v[15:8]);
   endtask
   task psh(input logic [14:0] v);
      @(posedge clk);
      pushv <= v;
      push <= 1'b1;
      @(posedge clk);
      push <= 1'b0;
   endtask
   task pp(input logic [14:0] e);
      @(posedge clk);
      pop <= 1'b1;
      #1 chk(popv, e);
      @(posedge clk);
      pop <= 1'b0;
   endtask
   task br(input logic lit, input logic [14:0] p, input logic [7:0] w, input logic [8:0] o,
      input logic [14:0] e);
      @(posedge clk);
      pc <= p;
      wreg <= w;
      opnd <= o;
      branch_by_working_reg <= !lit;
      branch_by_literal <= lit;
      #1 chk(pct, e);
      chk(program_counter_low, 1'b1);
      @(posedge clk);
      branch_by_working_reg <= 1'b0;
      branch_by_literal <= 1'b0;
   endtask
   task report_and_stop;
      $display("checked=%0d errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      n_errors++;
      report_and_stop;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(4'hb, 8'h1f);
      br(1'b0, 15'h00f0, 8'hff, 9'h000, 15'h01f0);
      br(1'b1, 15'h0100, 8'h00, 9'h1fe, 15'h00ff);
      wr(4'ha, 8'h55);
      for (int i = 0; i < 17; i++)
         psh(15'h4000 | i[14:0]);
      rd(4'hb, 8'h00);
      rd(4'hc, 8'h10);
      rd(4'he, 8'h01);
      pp(15'h4010);
      rd(4'hb, 8'h1f);
      @(posedge clk);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      rd(4'he, 8'h03);
      rd(4'ha, 8'h55);
      wr(4'hb, 8'h05);
      wr(4'hc, 8'hab);
      wr(4'hd, 8'h12);
      rd(4'hd, 8'h12);
      pp(15'h12ab);
      rd(4'hb, 8'h04);
      wr(4'he, 8'h00);
      wr(4'hb, 8'h0f);
      fre <= 1'b1;
      psh(15'h0001);
      #1 chk(sres, 1'b1);
      rd(4'he, 8'h01);
      fre <= 1'b0;
      setp(4'h4, 16'h0070);
      wr(4'h0, 8'h3c);
      rd(4'h0, 8'h3c);
      setp(4'h6, 16'h0000);
      wr(4'h1, 8'hff);
      rd(4'h1, 8'h00);
      setp(4'h4, 16'h2050);
      wr(4'h0, 8'h5a);
      setp(4'h4, 16'h00a0);
      rd(4'h0, 8'h5a);
      setp(4'h4, 16'h20a0);
      rd(4'h0, 8'h00);
      setp(4'h4, 16'h8034);
      rd(4'h5, 8'h80);
      wr(4'h0, 8'h77);
      rd(4'h0, 8'h91);
      report_and_stop;
   end
endmodule // tb_pc_branch_stack_indirect_addr
`default_nettype wire
